/* File: rtl/swc_config_regs.sv */
// selective-wake configuration register bank with APB slave
//
// What this block does
// RL1 - calibration mode follows control bit 7
// RL2 - trim unlocked only when key is 11
// RL3 - transmit pin is trim sync reference
// RL4 - option register writable only when unlocked
// RL5 - timeout alert gated by irq enable bit
// RL6 - timeout flag updates only in wake mode
// RL7 - alert only when enabled, normal or stop
// RL8 - reserved control and sample bits read zero
// RL9 - selective wake needs config-valid flag set
// RL10 - host sets config-valid after checking setup
// RL11 - config-valid cleared on wake, reset, change
// RL12 - quanta-per-bit field gives bit length
// RL13 - quantum length from clock select input
// RL14 - sample point is six-bit binary fraction
// RL15 - identifier bits 28..21 in top register
// RL16 - standard identifier sits at 28 down to 18
// RL17 - control cleared; restart clears low nibble
// RL18 - quanta reset a0; restart keeps contents
// RL19 - sample point 33, id 00 at reset
// RL20 - writes to reserved bits are ignored
//
// Our own choice: register access over APB.
`timescale 1ns/1ps

module swc_config_regs #(
  parameter int unsigned SP_W = 6
) (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      clkEn,
  input  wire swc_pkg::swc_apb_req_type  apbReq,
  output swc_pkg::swc_apb_rsp_type       apbRsp,
  input  wire logic                      softReset,
  input  wire logic                      restartEvent,
  input  wire logic                      wakeEvent,
  input  wire logic                      selWakeMode,
  input  wire logic                      normalMode,
  input  wire logic                      stopMode,
  input  wire logic                      busTimeoutEvent,
  input  wire logic                      canTransmitPin,
  input  wire logic [1:0]                quantumClockSelect,
  output logic                           oscTrimEnable,
  output logic                           trimSyncRef,
  output logic                           selWakeAllowed,
  output logic                           busTimeoutAlert,
  output logic                           busTimeoutFlag,
  output logic [7:0]                     quantaPerBit,
  output logic [SP_W-1:0]                samplePointFraction,
  output logic [9:0]                     bitLengthOsc,
  output logic [10:0]                    standardFrameId,
  output logic [7:0]                     frameIdUpperBits,
  output logic [7:0]                     lowPowerRxOption
);

  // register state
  logic [7:0]  control_r;
  logic [7:0]  control_nxt;
  logic [7:0]  bitQuanta_r;
  logic [7:0]  bitQuanta_nxt;
  logic [7:0]  samplePt_r;
  logic [7:0]  samplePt_nxt;
  logic [7:0]  frameId_r;
  logic [7:0]  frameId_nxt;
  logic [7:0]  rxOption_r;
  logic [7:0]  rxOption_nxt;
  logic        timeout_r;
  logic        timeout_nxt;
  logic        alert_r;
  logic [1:0]  txSync_r;
  logic        trim_r;
  logic        trimRef_r;
  logic [9:0]  bitLen_r;
  logic [31:0] readData_r;
  logic        readErr_r;

  // address decode
  wire logic [9:0] wordIdx    = apbReq.paddr[11:2];
  wire logic       setupPhase = apbReq.psel & ~apbReq.penable;
  wire logic       accessWr   = apbReq.psel & apbReq.penable & apbReq.pwrite;
  wire logic       hitControl = (wordIdx == {2'b00, swc_pkg::IDX_CONTROL});
  wire logic       hitQuanta  = (wordIdx == {2'b00, swc_pkg::IDX_BIT_QUANTA});
  wire logic       hitSample  = (wordIdx == {2'b00, swc_pkg::IDX_SAMPLE_PT});
  wire logic       hitFrameId = (wordIdx == {2'b00, swc_pkg::IDX_FRAME_ID});
  wire logic       hitOption  = (wordIdx == {2'b00, swc_pkg::IDX_RX_OPTION});
  wire logic       hitStatus  = (wordIdx == {2'b00, swc_pkg::IDX_STATUS});
  wire logic       addrHit    = hitControl | hitQuanta | hitSample | hitFrameId | hitOption | hitStatus;
  wire logic [7:0] wrByte     = apbReq.pwdata[7:0];

  wire logic       wrControl  = accessWr & hitControl;
  wire logic       wrQuanta   = accessWr & hitQuanta;
  wire logic       wrSample   = accessWr & hitSample;
  wire logic       wrFrameId  = accessWr & hitFrameId;
  wire logic       wrStatus   = accessWr & hitStatus;

  wire logic [1:0] trimKey    = control_r[swc_pkg::POS_KEY_HI:swc_pkg::POS_KEY_LO];
  wire logic       unlocked   = (trimKey == swc_pkg::KEY_UNLOCKED); // see RL2
  // option register refuses writes silently while the key is wrong
  wire logic       wrOption   = accessWr & hitOption & unlocked; // see RL4

  // any change of selective-wake setup data voids the validation
  wire logic       cfgChanged = wrQuanta | wrSample | wrFrameId | wrOption; // see RL11
  wire logic       cfgValid   = control_r[swc_pkg::POS_CFG_VALID];
  wire logic       wakeActive = selWakeMode & cfgValid; // see RL9
  wire logic       opModeOk   = normalMode | stopMode;
  wire logic       irqEnable  = control_r[swc_pkg::POS_TO_IRQ_EN];
  // alert needs the mask bit, an active wake setup and a suitable mode
  wire logic       alertFire  = busTimeoutEvent & irqEnable & wakeActive & opModeOk; // see RL5 RL7
  wire logic       restartClr = restartEvent & ~softReset;

  // control register next value
  always_comb
  begin
    control_nxt = control_r;
    if (softReset)
    begin
      control_nxt = swc_pkg::RST_CONTROL; // see RL17
    end
    else if (restartEvent)
    begin
      // upper nibble undefined after restart; we simply keep it
      control_nxt = control_r & swc_pkg::RESTART_KEEP; // see RL17
    end
    else
    begin
      if (wrControl)
      begin
        control_nxt = wrByte & swc_pkg::CONTROL_WMASK; // see RL8 RL20
      end
      // host setting the flag in the same write beats nothing else
      if (cfgChanged || wakeEvent)
      begin
        control_nxt[swc_pkg::POS_CFG_VALID] = 1'b0; // see RL11
      end
    end
  end

  // bit timing, identifier and option registers
  always_comb
  begin
    bitQuanta_nxt = bitQuanta_r;
    samplePt_nxt  = samplePt_r;
    frameId_nxt   = frameId_r;
    rxOption_nxt  = rxOption_r;
    if (softReset)
    begin
      bitQuanta_nxt = swc_pkg::RST_BIT_QUANTA; // see RL18
      samplePt_nxt  = swc_pkg::RST_SAMPLE_PT; // see RL19
      frameId_nxt   = swc_pkg::RST_FRAME_ID; // see RL19
      rxOption_nxt  = swc_pkg::RST_RX_OPTION;
    end
    else if (!restartEvent)
    begin
      if (wrQuanta)
      begin
        bitQuanta_nxt = wrByte; // see RL12
      end
      if (wrSample)
      begin
        samplePt_nxt = wrByte & swc_pkg::SAMPLE_PT_WMASK; // see RL8 RL20
      end
      if (wrFrameId)
      begin
        frameId_nxt = wrByte; // see RL15
      end
      if (wrOption)
      begin
        rxOption_nxt = wrByte; // see RL4
      end
    end
  end

  // timeout flag: set wins over a write-one clear, frozen outside wake mode
  always_comb
  begin
    timeout_nxt = timeout_r;
    if (softReset)
    begin
      timeout_nxt = 1'b0;
    end
    else if (selWakeMode)
    begin
      if (busTimeoutEvent)
      begin
        timeout_nxt = 1'b1; // see RL6
      end
      else if (wrStatus && wrByte[swc_pkg::POS_ST_TIMEOUT])
      begin
        timeout_nxt = 1'b0; // see RL6
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      control_r   <= swc_pkg::RST_CONTROL;
      bitQuanta_r <= swc_pkg::RST_BIT_QUANTA;
      samplePt_r  <= swc_pkg::RST_SAMPLE_PT;
      frameId_r   <= swc_pkg::RST_FRAME_ID;
      rxOption_r  <= swc_pkg::RST_RX_OPTION;
      timeout_r   <= 1'b0;
    end
    else if (clkEn)
    begin
      control_r   <= control_nxt;
      bitQuanta_r <= bitQuanta_nxt;
      samplePt_r  <= samplePt_nxt;
      frameId_r   <= frameId_nxt;
      rxOption_r  <= rxOption_nxt;
      timeout_r   <= timeout_nxt;
    end
  end

  // transmit pin comes from the host: two flops before use
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      txSync_r <= 2'b00;
    end
    else if (clkEn)
    begin
      txSync_r <= {txSync_r[0], canTransmitPin};
    end
  end

  // only the second flop may be read outside the synchroniser
  wire logic pinSynced = txSync_r[1];

  // trim reference and derived timing, registered
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      trim_r    <= 1'b0;
      trimRef_r <= 1'b0;
      bitLen_r  <= 10'h000;
      alert_r   <= 1'b0;
    end
    else if (clkEn)
    begin
      trim_r    <= control_r[swc_pkg::POS_OSC_TRIM] & unlocked; // see RL1 RL2
      trimRef_r <= txSync_r[1] & control_r[swc_pkg::POS_OSC_TRIM] & unlocked; // see RL3
      // a quantum is 2^select oscillator periods; bit length follows
      bitLen_r  <= 10'({2'b00, bitQuanta_r} << quantumClockSelect); // see RL12 RL13
      alert_r   <= alertFire;
    end
  end

  // read mux, latched during setup so prdata comes from a flop
  wire logic [7:0] statusByte = {5'h00, wakeActive, trim_r, timeout_r};
  wire logic [7:0] readByte   = hitControl ? control_r :
                                hitQuanta  ? bitQuanta_r :
                                hitSample  ? (samplePt_r & swc_pkg::SAMPLE_PT_WMASK) :
                                hitFrameId ? frameId_r :
                                hitOption  ? rxOption_r :
                                hitStatus  ? statusByte : 8'h00;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      readData_r <= 32'h0000_0000;
      readErr_r  <= 1'b0;
    end
    else if (clkEn && setupPhase)
    begin
      readData_r <= {24'h00_0000, readByte & (hitControl ? swc_pkg::CONTROL_WMASK : 8'hFF)}; // see RL8
      readErr_r  <= ~addrHit;
    end
  end

  // slave is always ready: one access cycle per transfer
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = apbReq.psel & apbReq.penable & readErr_r;
  assign apbRsp.prdata  = readData_r;

  assign oscTrimEnable       = trim_r;
  assign trimSyncRef         = trimRef_r;
  assign selWakeAllowed      = cfgValid; // see RL9
  assign busTimeoutAlert     = alert_r;
  assign busTimeoutFlag      = timeout_r;
  assign quantaPerBit        = bitQuanta_r;
  assign samplePointFraction = samplePt_r[SP_W-1:0]; // see RL14
  assign bitLengthOsc        = bitLen_r;
  assign frameIdUpperBits    = frameId_r; // see RL15
  assign lowPowerRxOption    = rxOption_r; // see RL4
  // top eight of the eleven standard id bits; lower three are driven as zero
  assign standardFrameId     = {frameId_r, 3'b000}; // see RL16

  // checks
  a_key_locks_trim: assert property (@(posedge core_clk) disable iff (reset) // see RL2
    (clkEn && trimKey != swc_pkg::KEY_UNLOCKED) |=> !oscTrimEnable)
    else $error("trim active with wrong key");

  a_trim_follows_bit: assert property (@(posedge core_clk) disable iff (reset) // see RL1
    (clkEn && control_r[swc_pkg::POS_OSC_TRIM] && unlocked) |=> oscTrimEnable)
    else $error("trim not enabled");

  a_option_locked: assert property (@(posedge core_clk) disable iff (reset) // see RL4
    (clkEn && !unlocked && !softReset) |=> $stable(rxOption_r))
    else $error("option changed while locked");

  a_alert_masked: assert property (@(posedge core_clk) disable iff (reset) // see RL5
    (clkEn && busTimeoutEvent && !irqEnable) |=> !busTimeoutAlert)
    else $error("masked timeout raised alert");

  a_alert_raised: assert property (@(posedge core_clk) disable iff (reset) // see RL7
    (clkEn && alertFire) |=> busTimeoutAlert)
    else $error("timeout alert missing");

  a_alert_cause: assert property (@(posedge core_clk) disable iff (reset) // see RL7
    busTimeoutAlert |-> $past(wakeActive) && $past(opModeOk))
    else $error("alert outside wake or mode");

  a_flag_frozen: assert property (@(posedge core_clk) disable iff (reset) // see RL6
    (clkEn && !selWakeMode && !softReset) |=> $stable(busTimeoutFlag))
    else $error("timeout flag moved outside wake mode");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (reset) // see RL8
    (control_r[3:1] == 3'b000) && (samplePt_r[7:6] == 2'b00))
    else $error("reserved bit set");

  a_valid_cleared: assert property (@(posedge core_clk) disable iff (reset) // see RL11
    (clkEn && (cfgChanged || wakeEvent || restartClr)) |=> !selWakeAllowed)
    else $error("config valid not cleared");

  a_soft_defaults: assert property (@(posedge core_clk) disable iff (reset) // see RL17
    (clkEn && softReset) |=> control_r == 8'h00 && quantaPerBit == 8'hA0 && samplePt_r == 8'h33 && frameId_r == 8'h00)
    else $error("soft reset values wrong");

  a_restart_nibble: assert property (@(posedge core_clk) disable iff (reset) // see RL17
    (clkEn && restartClr) |=> control_r[3:0] == 4'h0 && $stable(bitQuanta_r))
    else $error("restart handling wrong");

  a_bit_length: assert property (@(posedge core_clk) disable iff (reset) // see RL13
    (clkEn && quantumClockSelect == 2'd0) ##1 (clkEn && $stable(bitQuanta_r)) |-> bitLengthOsc == {2'b00, bitQuanta_r})
    else $error("bit length wrong");

  a_flag_set_wins: assert property (@(posedge core_clk) disable iff (reset) // see RL6
    (clkEn && !softReset && selWakeMode && busTimeoutEvent) |=> busTimeoutFlag)
    else $error("timeout flag not set");

  a_flag_write_clear: assert property (@(posedge core_clk) disable iff (reset) // see RL6
    (clkEn && !softReset && selWakeMode && !busTimeoutEvent && wrStatus && wrByte[swc_pkg::POS_ST_TIMEOUT])
      |=> !busTimeoutFlag)
    else $error("timeout flag not cleared");

  a_option_written: assert property (@(posedge core_clk) disable iff (reset) // see RL4
    (clkEn && wrOption && !softReset && !restartEvent) |=> lowPowerRxOption == $past(wrByte))
    else $error("option write lost");

  // a same-cycle wake clears the flag, so it is left out here
  a_valid_set: assert property (@(posedge core_clk) disable iff (reset) // see RL9
    (clkEn && wrControl && wrByte[swc_pkg::POS_CFG_VALID] && !softReset && !restartEvent && !wakeEvent)
      |=> selWakeAllowed)
    else $error("config valid not set");

  a_sync_ref_gated: assert property (@(posedge core_clk) disable iff (reset) // see RL3
    (clkEn && !(control_r[swc_pkg::POS_OSC_TRIM] && unlocked)) |=> !trimSyncRef)
    else $error("sync reference outside trim");

  a_sync_ref_pin: assert property (@(posedge core_clk) disable iff (reset) // see RL3
    (clkEn && control_r[swc_pkg::POS_OSC_TRIM] && unlocked) |=> trimSyncRef == $past(pinSynced))
    else $error("sync reference not following pin");

  a_quanta_write: assert property (@(posedge core_clk) disable iff (reset) // see RL12
    (clkEn && wrQuanta && !softReset && !restartEvent) |=> quantaPerBit == $past(wrByte))
    else $error("quanta write lost");

  a_sample_write: assert property (@(posedge core_clk) disable iff (reset) // see RL14
    (clkEn && wrSample && !softReset && !restartEvent)
      |=> samplePt_r == ($past(wrByte) & swc_pkg::SAMPLE_PT_WMASK))
    else $error("sample point write wrong");

  a_frame_id_write: assert property (@(posedge core_clk) disable iff (reset) // see RL15
    (clkEn && wrFrameId && !softReset && !restartEvent) |=> frameIdUpperBits == $past(wrByte))
    else $error("frame id write lost");

  a_state_frozen: assert property (@(posedge core_clk) disable iff (reset)
    !clkEn |=> $stable(control_r) && $stable(bitQuanta_r) && $stable(frameId_r) && $stable(timeout_r))
    else $error("state moved while clock enable low");

endmodule

/* File: rtl/swc_pkg.sv */
// package: register map, reset values, field positions and bus carriers for the selective-wake config bank
package swc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL     = 8'h20;
  localparam logic [7:0] IDX_BIT_QUANTA  = 8'h21;
  localparam logic [7:0] IDX_SAMPLE_PT   = 8'h22;
  localparam logic [7:0] IDX_FRAME_ID    = 8'h23;
  localparam logic [7:0] IDX_RX_OPTION   = 8'h30;
  localparam logic [7:0] IDX_STATUS      = 8'h31;

  localparam logic [7:0] RST_CONTROL     = 8'h00;
  localparam logic [7:0] RST_BIT_QUANTA  = 8'hA0;
  localparam logic [7:0] RST_SAMPLE_PT   = 8'h33;
  localparam logic [7:0] RST_FRAME_ID    = 8'h00;
  localparam logic [7:0] RST_RX_OPTION   = 8'h00;

  localparam int unsigned POS_OSC_TRIM   = 7;
  localparam int unsigned POS_KEY_HI     = 6;
  localparam int unsigned POS_KEY_LO     = 5;
  localparam int unsigned POS_TO_IRQ_EN  = 4;
  localparam int unsigned POS_CFG_VALID  = 0;
  localparam logic [1:0]  KEY_UNLOCKED   = 2'b11;

  localparam logic [7:0] CONTROL_WMASK   = 8'hF1;
  localparam logic [7:0] SAMPLE_PT_WMASK = 8'h3F;
  localparam logic [7:0] RESTART_KEEP    = 8'hF0;

  localparam int unsigned POS_ST_TIMEOUT = 0;
  localparam int unsigned POS_ST_TRIM    = 1;
  localparam int unsigned POS_ST_WAKE_EN = 2;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } swc_apb_req_type;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } swc_apb_rsp_type;

endpackage

/* File: tb/swc_host_model.sv */
// host model: apb master and transmit pin drive
`timescale 1ns/1ps
module swc_host_model (
  input  wire logic                     core_clk,
  input  wire logic                     trimOn,
  input  wire swc_pkg::swc_apb_rsp_type apbRsp,
  output swc_pkg::swc_apb_req_type      apbReq,
  output logic                          canTransmitPin
);
  logic [2:0] div;
  initial
  begin
    apbReq = '0;
    div = 3'h0;
    canTransmitPin = 1'b1;
  end
  // pin is the trim reference only while trimming; idles high otherwise
  always @(posedge core_clk)
  begin
    div <= div + 3'h1;
    canTransmitPin <= trimOn ? div[2] : 1'b1;
  end
  // config bytes sit in pwdata[7:0]; no wait count assumed, only the watchdog ends a hang
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
    @(posedge core_clk);
    apbReq <= '{1'b1, 1'b0, wr, {2'b00, idx, 2'b00}, {24'h00_0000, wd}};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    @(posedge core_clk);
    while (apbRsp.pready !== 1'b1)
      @(posedge core_clk);
    rd = apbRsp.prdata[7:0];
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask
endmodule

/* File: tb/tb.sv */
// testbench: selective-wake config bank driven by the host model
`timescale 1ns/1ps
module tb;
  logic                     core_clk, reset, clkEn, softReset, restartEvent, wakeEvent, busTimeoutEvent;
  logic                     selWakeMode, normalMode, stopMode, canTransmitPin, trimSyncRef;
  logic                     oscTrimEnable, selWakeAllowed, busTimeoutAlert, busTimeoutFlag, e, hi, lo;
  logic [1:0]               quantumClockSelect, sel;
  logic [7:0]               quantaPerBit, frameIdUpperBits, lowPowerRxOption, d, q, s, id, c;
  logic [5:0]               samplePointFraction;
  logic [9:0]               bitLengthOsc;
  logic [10:0]              standardFrameId;
  swc_pkg::swc_apb_req_type apbReq;
  swc_pkg::swc_apb_rsp_type apbRsp;
  int                       n_errors;
  int                       checks;

  swc_host_model host (.core_clk, .trimOn(oscTrimEnable), .apbRsp, .apbReq, .canTransmitPin);
  swc_config_regs dut (.core_clk, .reset, .clkEn, .apbReq, .apbRsp, .softReset, .restartEvent,
    .wakeEvent, .selWakeMode, .normalMode, .stopMode, .busTimeoutEvent, .canTransmitPin,
    .quantumClockSelect, .oscTrimEnable, .trimSyncRef, .selWakeAllowed, .busTimeoutAlert,
    .busTimeoutFlag, .quantaPerBit, .samplePointFraction, .bitLengthOsc, .standardFrameId,
    .frameIdUpperBits, .lowPowerRxOption);

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    final_report();
  end

  function automatic logic exp_alert(logic [3:0] v);
    return v[3] & v[2] & (v[1] | v[0]);
  endfunction
  function automatic logic exp_trim(logic [7:0] v);
    return v[7] & (v[6:5] == 2'b11);
  endfunction
  function automatic logic [9:0] exp_len(logic [7:0] v, logic [1:0] k);
    return {2'b00, v} << k;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    host.xfer(1'b1, idx, v, d, e);
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    host.xfer(1'b0, idx, 8'h00, d, e);
    chk(nm, d, exp);
  endtask
  task automatic defaults();
    rdc("control", swc_pkg::IDX_CONTROL, 8'h00);
    rdc("quanta", swc_pkg::IDX_BIT_QUANTA, 8'hA0);
    rdc("sample", swc_pkg::IDX_SAMPLE_PT, 8'h33);
    rdc("frame_id", swc_pkg::IDX_FRAME_ID, 8'h00);
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'h6432_dd05));
    {softReset, restartEvent, wakeEvent, busTimeoutEvent, selWakeMode, normalMode, stopMode} = 7'h00;
    quantumClockSelect = 2'b00;
    clkEn = 1'b1;
    reset = 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    defaults();
    host.xfer(1'b0, 8'h24, 8'h00, d, e);
    chk("slverr", e, 1'b1);
    chk("unmapped", d, 8'h00);
    // random timing and id values; reserved sample bits written too
    repeat (8)
    begin
      q = 8'($urandom);
      s = 8'($urandom);
      id = 8'($urandom);
      sel = 2'($urandom);
      quantumClockSelect <= sel;
      wr(swc_pkg::IDX_BIT_QUANTA, q);
      wr(swc_pkg::IDX_SAMPLE_PT, s);
      wr(swc_pkg::IDX_FRAME_ID, id);
      rdc("quanta", swc_pkg::IDX_BIT_QUANTA, q);
      rdc("sample", swc_pkg::IDX_SAMPLE_PT, s & 8'h3F);
      rdc("frame_id", swc_pkg::IDX_FRAME_ID, id);
      chk("quanta_out", quantaPerBit, q);
      chk("sp_out", samplePointFraction, s[5:0]);
      chk("id_out", frameIdUpperBits, id);
      chk("std_id", standardFrameId, {id, 3'b000});
      chk("bit_len", bitLengthOsc, exp_len(q, sel));
    end
    // every key code with trim requested; host sets valid only on odd codes
    for (int k = 0; k < 4; k++)
    begin
      c = 8'($urandom) | 8'h80;
      c[6:5] = 2'(k);
      c[0] = k[0];
      wr(swc_pkg::IDX_CONTROL, c);
      rdc("control", swc_pkg::IDX_CONTROL, c & 8'hF1);
      chk("trim", oscTrimEnable, exp_trim(c));
      chk("allowed", selWakeAllowed, c[0]);
      hi = 1'b0;
      lo = 1'b0;
      repeat (12)
      begin
        @(posedge core_clk);
        hi = hi | trimSyncRef;
        lo = lo | !trimSyncRef;
      end
      chk("sync_ref", hi, exp_trim(c));
      chk("sync_low", lo, 1'b1);
    end
    // data change and wake both drop the valid flag
    wr(swc_pkg::IDX_CONTROL, 8'h01);
    wr(swc_pkg::IDX_BIT_QUANTA, 8'($urandom));
    repeat (2) @(posedge core_clk);
    chk("valid_data", selWakeAllowed, 1'b0);
    wr(swc_pkg::IDX_CONTROL, 8'h01);
    wakeEvent <= 1'b1;
    @(posedge core_clk);
    wakeEvent <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("valid_wake", selWakeAllowed, 1'b0);
    // option register: locked key first, then unlocked
    q = 8'($urandom) | 8'h01;
    wr(swc_pkg::IDX_RX_OPTION, q);
    @(posedge core_clk);
    chk("opt_locked", lowPowerRxOption, 8'h00);
    wr(swc_pkg::IDX_CONTROL, 8'h60);
    wr(swc_pkg::IDX_RX_OPTION, q);
    repeat (2) @(posedge core_clk);
    chk("opt_open", lowPowerRxOption, q);
    // timeout event over irq enable, wake mode and operating modes
    for (int i = 0; i < 16; i++)
    begin
      selWakeMode <= 1'b1;
      wr(swc_pkg::IDX_STATUS, 8'h01);
      {selWakeMode, normalMode, stopMode} <= i[2:0];
      wr(swc_pkg::IDX_CONTROL, {3'b000, i[3], 4'h1});
      @(posedge core_clk);
      busTimeoutEvent <= 1'b1;
      @(posedge core_clk);
      busTimeoutEvent <= 1'b0;
      #1;
      chk("alert", busTimeoutAlert, exp_alert(i[3:0]));
      chk("flag", busTimeoutFlag, i[2]);
      rdc("status", swc_pkg::IDX_STATUS, {5'h00, i[2], 1'b0, i[2]});
    end
    // clock enable low: a write is lost and state holds
    id = frameIdUpperBits;
    clkEn <= 1'b0;
    wr(swc_pkg::IDX_FRAME_ID, ~id);
    clkEn <= 1'b1;
    @(posedge core_clk);
    chk("frozen", frameIdUpperBits, id);
    // restart keeps upper nibble, soft reset restores everything
    wr(swc_pkg::IDX_CONTROL, 8'hF1);
    @(posedge core_clk);
    restartEvent <= 1'b1;
    @(posedge core_clk);
    restartEvent <= 1'b0;
    rdc("restart", swc_pkg::IDX_CONTROL, 8'hF0);
    wr(swc_pkg::IDX_FRAME_ID, 8'hFF);
    @(posedge core_clk);
    softReset <= 1'b1;
    @(posedge core_clk);
    softReset <= 1'b0;
    defaults();
    chk("opt_soft", lowPowerRxOption, 8'h00);
    final_report();
  end
endmodule
